// ==== include/slp_pkg.sv ====
/*
 Shared constants and types of the sleep and wake-up controller: device register
 offsets and bit positions, wake-up stabilisation timing, and the host's APB map.
 Assumes a single 200 MHz system clock for both ends.
*/
package slp_pkg;

    // Device register offsets.
    localparam logic [7:0] ADDR_POWER = 8'h01;
    localparam logic [7:0] ADDR_TOUCH0 = 8'h70;
    localparam logic [7:0] ADDR_KEY1 = 8'hc0;
    localparam logic [7:0] ADDR_KEY2 = 8'hc1;

    // Device register reset value.
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions inside the device registers.
    localparam int SLEEP_BIT = 1;
    localparam int TP_EN_BIT = 7;
    localparam int TP_WAKE_BIT = 3;
    localparam int KS_EN_BIT = 7;
    localparam int KS_WAKE_BIT = 7;

    // Oscillator and PLL stabilisation after wake-up.
    localparam int CLK_MHZ = 200;
    localparam int WAKE_TIME_MS = 10;
    localparam int WAKE_CYCLES = WAKE_TIME_MS * 1000 * CLK_MHZ;
    localparam int WAKE_CNT_W = 24;

    // Host APB register byte addresses.
    localparam logic [11:0] OFF_CMD = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h008;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h00c;

    // Host register fields.
    localparam int CMD_GO_BIT = 31;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ASLEEP_BIT = 1;
    localparam int STAT_RDATA_LSB = 8;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_WAKE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    typedef enum logic [1:0] {
        SLP_RUN,
        SLP_SLEEP,
        SLP_WAKE
    } slp_state_t;

endpackage

// ==== include/slp_link_if.sv ====
/*
 Register link between the host controller and the sleeping device.
 Assumes both ends run on the same system clock; the bench joins them.
*/
`timescale 1ns/1ps
interface slp_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;
    logic asleep;

    modport dev (
        input req,
        input we,
        input addr,
        input wdata,
        output rdata,
        output ack,
        output asleep
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input rdata,
        input ack,
        input asleep
    );
endinterface

// ==== design/slp_sync.sv ====
/*
 Two flip-flop synchroniser for asynchronous pins.
 Assumes multi-bit inputs are stable while they are sampled.
*/
`timescale 1ns/1ps
module slp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Pins and synchronised copy.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } slp_sync_st_t;

    slp_sync_st_t q;
    slp_sync_st_t d;

    always_comb begin
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.s2;

endmodule

// ==== design/slp_device.sv ====
/*
 Device end of the sleep and wake-up controller: power, touch and key-scan control
 registers, the sleep state machine, wake-up stabilisation and sleep pin levels.
 Assumes touch and key pins are asynchronous and that normal pin levels come from
 core logic on the same clock.
*/
// Overview of operation
// R01: Sleep bit set sleeps, cleared resumes.
// R02: Sleep stops oscillator, memory, ROM, inputs.
// R03: PWM outputs keep register-driven levels in sleep.
// R04: Touch wakes when both touch enables set.
// R05: Host arms manual touch before sleeping.
// R06: Keystroke wakes when both key enables set.
// R07: Waking keystroke is never captured.
// R08: Host waits ten milliseconds after wake-up.
// R09: Sleep drives fixed high and low pins.
// R10: Event wake clears sleep bit, restarts clocks.
`timescale 1ns/1ps
module slp_device #(
    parameter int WAKE_CYCLES = slp_pkg::WAKE_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register link.
    slp_link_if.dev link,
    // Wake-up pins.
    input wire logic touch_event_in,
    input wire logic key_press_in,
    input wire logic [7:0] key_code_in,
    // Captured key.
    output logic [7:0] key_code_out,
    output logic key_valid_out,
    // Clock and memory run enables.
    output logic osc_run_out,
    output logic mem_run_out,
    output logic rom_run_out,
    // Normal pin levels from core logic.
    input wire logic core_wait_n_in,
    input wire logic core_int_n_in,
    input wire logic core_ram_cs_n_in,
    input wire logic core_ram_wr_n_in,
    input wire logic core_rom_cs_n_in,
    input wire logic core_ram_oe_n_in,
    input wire logic core_vsync_in,
    input wire logic core_hsync_in,
    input wire logic core_pclk_in,
    input wire logic core_pixel_data_valid_in,
    input wire logic core_pwm1_in,
    input wire logic core_pwm2_in,
    input wire logic [5:0] core_gpio_in,
    input wire logic [18:0] core_video_mem_addr_in,
    input wire logic [15:0] core_pixel_data_in,
    // Panel and memory pins.
    output logic wait_n_out,
    output logic int_n_out,
    output logic ram_cs_n_out,
    output logic ram_wr_n_out,
    output logic rom_cs_n_out,
    output logic ram_oe_n_out,
    output logic vsync_out,
    output logic hsync_out,
    output logic pclk_out,
    output logic pixel_data_valid_out,
    output logic pwm1_out,
    output logic pwm2_out,
    output logic [5:0] gpio_out,
    output logic [18:0] video_mem_addr_out,
    output logic [15:0] pixel_data_out
);

    typedef struct packed {
        slp_pkg::slp_state_t st;
        logic [slp_pkg::WAKE_CNT_W-1:0] cnt;
        logic [7:0] power_control;
        logic [7:0] touch_control_zero;
        logic [7:0] key_scan_control_one;
        logic [7:0] key_scan_control_two;
        logic ack;
        logic [7:0] rdata;
        logic asleep;
        logic key_prev;
        logic key_block;
        logic [7:0] key_code;
        logic key_valid;
        logic osc_run;
        logic mem_run;
        logic rom_run;
        logic wait_n;
        logic int_n;
        logic ram_cs_n;
        logic ram_wr_n;
        logic rom_cs_n;
        logic ram_oe_n;
        logic vsync;
        logic hsync;
        logic pclk;
        logic de;
        logic pwm1;
        logic pwm2;
        logic [5:0] gpio;
        logic [18:0] va;
        logic [15:0] pdat;
    } slp_dev_st_t;

    localparam logic [slp_pkg::WAKE_CNT_W-1:0] WAKE_LAST =
        slp_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1);

    slp_dev_st_t q;
    slp_dev_st_t d;
    logic touch_s;
    logic key_s;
    logic [7:0] key_code_s;
    logic touch_wake;
    logic key_wake;
    logic sleeping;

    ////////////////////////////////////////////////////////////////////////////////

    slp_sync #(
        .WIDTH(10)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({touch_event_in, key_press_in, key_code_in}),
        .sync_out({touch_s, key_s, key_code_s})
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        d = q;
        d.ack = 1'b0;
        touch_wake = q.touch_control_zero[slp_pkg::TP_EN_BIT] &
            q.touch_control_zero[slp_pkg::TP_WAKE_BIT] & touch_s; // R04
        key_wake = q.key_scan_control_one[slp_pkg::KS_EN_BIT] &
            q.key_scan_control_two[slp_pkg::KS_WAKE_BIT] & key_s; // R06

        // The link stays alive in sleep, otherwise software could never wake us.
        if (link.req && !q.ack) begin
            d.ack = 1'b1;
            if (link.we) begin
                unique case (link.addr)
                    slp_pkg::ADDR_POWER: d.power_control = link.wdata; // R01
                    slp_pkg::ADDR_TOUCH0: d.touch_control_zero = link.wdata;
                    slp_pkg::ADDR_KEY1: d.key_scan_control_one = link.wdata;
                    slp_pkg::ADDR_KEY2: d.key_scan_control_two = link.wdata;
                    default: d.rdata = q.rdata;
                endcase
            end else begin
                unique case (link.addr)
                    slp_pkg::ADDR_POWER: d.rdata = q.power_control;
                    slp_pkg::ADDR_TOUCH0: d.rdata = q.touch_control_zero;
                    slp_pkg::ADDR_KEY1: d.rdata = q.key_scan_control_one;
                    slp_pkg::ADDR_KEY2: d.rdata = q.key_scan_control_two;
                    default: d.rdata = 8'h00;
                endcase
            end
        end

        // A released key lifts the block left by a waking keystroke.
        if (!key_s) begin
            d.key_block = 1'b0; // R07
        end

        unique case (q.st)
            slp_pkg::SLP_RUN: begin
                if (d.power_control[slp_pkg::SLEEP_BIT]) begin
                    d.st = slp_pkg::SLP_SLEEP; // R01
                end
            end
            slp_pkg::SLP_SLEEP: begin
                if (!d.power_control[slp_pkg::SLEEP_BIT]) begin
                    d.st = slp_pkg::SLP_WAKE; // R01
                    d.cnt = '0;
                end else if (touch_wake || key_wake) begin
                    d.power_control[slp_pkg::SLEEP_BIT] = 1'b0; // R10
                    d.st = slp_pkg::SLP_WAKE; // R10
                    d.cnt = '0;
                    d.key_block = key_wake; // R07
                end
            end
            slp_pkg::SLP_WAKE: begin
                if (d.power_control[slp_pkg::SLEEP_BIT]) begin
                    d.st = slp_pkg::SLP_SLEEP;
                end else if (q.cnt == WAKE_LAST) begin
                    d.st = slp_pkg::SLP_RUN; // R10
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
        endcase

        // Key capture only in normal operation; sleep ignores the pins otherwise.
        d.key_prev = key_s;
        d.key_valid = 1'b0;
        if (q.st == slp_pkg::SLP_RUN && key_s && !q.key_prev && !q.key_block) begin // R02
            d.key_code = key_code_s;
            d.key_valid = 1'b1;
        end

        sleeping = (d.st != slp_pkg::SLP_RUN);
        d.asleep = sleeping;
        d.osc_run = (d.st != slp_pkg::SLP_SLEEP); // R02
        d.mem_run = !sleeping; // R02
        d.rom_run = !sleeping; // R02

        // Pins hold their sleep levels until the clocks are stable again.
        if (sleeping) begin
            d.wait_n = 1'b1; // R09
            d.int_n = 1'b1;
            d.ram_cs_n = 1'b1;
            d.ram_wr_n = 1'b1;
            d.rom_cs_n = 1'b1;
            d.vsync = 1'b1;
            d.hsync = 1'b1;
            d.pclk = 1'b1;
            d.de = 1'b1;
            d.ram_oe_n = 1'b0; // R09
            d.gpio = 6'h00;
            d.va = 19'h00000;
            d.pdat = 16'h0000;
        end else begin
            d.wait_n = core_wait_n_in;
            d.int_n = core_int_n_in;
            d.ram_cs_n = core_ram_cs_n_in;
            d.ram_wr_n = core_ram_wr_n_in;
            d.rom_cs_n = core_rom_cs_n_in;
            d.vsync = core_vsync_in;
            d.hsync = core_hsync_in;
            d.pclk = core_pclk_in;
            d.de = core_pixel_data_valid_in;
            d.ram_oe_n = core_ram_oe_n_in;
            d.gpio = core_gpio_in;
            d.va = core_video_mem_addr_in;
            d.pdat = core_pixel_data_in;
        end
        // The PWM generator runs from its own register settings, so it passes through.
        d.pwm1 = core_pwm1_in; // R03
        d.pwm2 = core_pwm2_in; // R03
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.st <= slp_pkg::SLP_RUN;
            q.power_control <= slp_pkg::REG_RESET;
            q.touch_control_zero <= slp_pkg::REG_RESET;
            q.key_scan_control_one <= slp_pkg::REG_RESET;
            q.key_scan_control_two <= slp_pkg::REG_RESET;
            q.osc_run <= 1'b1;
            q.mem_run <= 1'b1;
            q.rom_run <= 1'b1;
            q.wait_n <= 1'b1;
            q.int_n <= 1'b1;
            q.ram_cs_n <= 1'b1;
            q.ram_wr_n <= 1'b1;
            q.rom_cs_n <= 1'b1;
            q.ram_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.ack = q.ack;
    assign link.rdata = q.rdata;
    assign link.asleep = q.asleep;
    assign key_code_out = q.key_code;
    assign key_valid_out = q.key_valid;
    assign osc_run_out = q.osc_run;
    assign mem_run_out = q.mem_run;
    assign rom_run_out = q.rom_run;
    assign wait_n_out = q.wait_n;
    assign int_n_out = q.int_n;
    assign ram_cs_n_out = q.ram_cs_n;
    assign ram_wr_n_out = q.ram_wr_n;
    assign rom_cs_n_out = q.rom_cs_n;
    assign ram_oe_n_out = q.ram_oe_n;
    assign vsync_out = q.vsync;
    assign hsync_out = q.hsync;
    assign pclk_out = q.pclk;
    assign pixel_data_valid_out = q.de;
    assign pwm1_out = q.pwm1;
    assign pwm2_out = q.pwm2;
    assign gpio_out = q.gpio;
    assign video_mem_addr_out = q.va;
    assign pixel_data_out = q.pdat;

endmodule

// ==== design/slp_host.sv ====
/*
 Host end: an APB slave whose command register drives one device register access
 over the link, with status, wake-up and completion interrupts.
 Assumes the device shares the system clock, so link signals need no synchroniser.
*/
`timescale 1ns/1ps
module slp_host (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    // Interrupt.
    output logic irq_out,
    // Register link.
    slp_link_if.host link
);

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic busy;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [1:0] istat;
        logic [1:0] imask;
        logic irq;
        logic asleep_prev;
    } slp_host_st_t;

    slp_host_st_t q;
    slp_host_st_t d;
    logic [1:0] events;

    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.prdata = 32'h00000000;
        events = 2'h0;
        d.asleep_prev = link.asleep;
        events[slp_pkg::IRQ_WAKE_BIT] = q.asleep_prev & ~link.asleep; // R08

        if (q.req && link.ack) begin
            d.req = 1'b0;
            d.busy = 1'b0;
            if (!q.we) begin
                d.rdata = link.rdata;
            end
            events[slp_pkg::IRQ_DONE_BIT] = 1'b1;
        end

        // One wait state: answer is prepared first, then committed with pready.
        if (psel_in && penable_in && !q.pready) begin
            d.pready = 1'b1;
            unique case (paddr_in)
                slp_pkg::OFF_CMD: begin
                    d.prdata[slp_pkg::CMD_WRITE_BIT] = q.we;
                    d.prdata[slp_pkg::CMD_ADDR_LSB +: 8] = q.addr;
                    d.prdata[7:0] = q.wdata;
                end
                slp_pkg::OFF_STATUS: begin
                    d.prdata[slp_pkg::STAT_BUSY_BIT] = q.busy;
                    d.prdata[slp_pkg::STAT_ASLEEP_BIT] = link.asleep;
                    d.prdata[slp_pkg::STAT_RDATA_LSB +: 8] = q.rdata;
                end
                slp_pkg::OFF_IRQ_STATUS: d.prdata[1:0] = q.istat;
                slp_pkg::OFF_IRQ_MASK: d.prdata[1:0] = q.imask;
                default: d.pslverr = 1'b1;
            endcase
        end

        if (psel_in && penable_in && q.pready) begin
            if (pwrite_in) begin
                if (paddr_in == slp_pkg::OFF_CMD && pwdata_in[slp_pkg::CMD_GO_BIT] &&
                    !q.busy) begin
                    d.busy = 1'b1;
                    d.req = 1'b1; // R01
                    d.we = pwdata_in[slp_pkg::CMD_WRITE_BIT];
                    d.addr = pwdata_in[slp_pkg::CMD_ADDR_LSB +: 8];
                    d.wdata = pwdata_in[7:0];
                end
                if (paddr_in == slp_pkg::OFF_IRQ_MASK) begin
                    d.imask = pwdata_in[1:0];
                end
            end else if (paddr_in == slp_pkg::OFF_IRQ_STATUS) begin
                // Clear only what was returned, so nothing set since is lost.
                d.istat = q.istat & ~q.prdata[1:0];
            end
        end

        d.istat = d.istat | events;
        d.irq = |(d.istat & d.imask);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.istat <= slp_pkg::IRQ_RESET;
            q.imask <= slp_pkg::IRQ_RESET;
        end else begin
            q <= d;
        end
    end

    assign pready_out = q.pready;
    assign prdata_out = q.prdata;
    assign pslverr_out = q.pslverr;
    assign irq_out = q.irq;
    assign link.req = q.req;
    assign link.we = q.we;
    assign link.addr = q.addr;
    assign link.wdata = q.wdata;

endmodule

// ==== sim/slp_link_props.sv ====
/*
 Checker for the register link between host and device ends.
 Assumes the testbench wires it to the link interface and the shared clock and reset.
*/
`timescale 1ns/1ps
module slp_link_props #(
    parameter int WAKE_CYCLES = 16
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Link signals.
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack,
    input wire logic asleep
);
    // The wake window is one cycle wide below and two cycles wide above to allow for the state register.
    localparam int WAKE_LO = WAKE_CYCLES - 1;
    localparam int WAKE_HI = WAKE_CYCLES + 2;
    logic pwr_wr;
    assign pwr_wr = req && !ack && we && addr == slp_pkg::ADDR_POWER;

    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    ////////////////////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    ack_follow_a: assert property (req && !ack |=> ack)
        else $error("link ack missing after request");
    ack_cause_a: assert property (ack |-> $past(req))
        else $error("link ack without request");
    req_hold_a: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
        else $error("link request changed before ack");
    req_drop_a: assert property (req && ack |=> !req)
        else $error("link request held after ack");
    sleep_enter_a: assert property (pwr_wr && wdata[slp_pkg::SLEEP_BIT] |-> ##1 asleep)
        else $error("sleep not entered after power write");
    wake_time_a: assert property (pwr_wr && !wdata[slp_pkg::SLEEP_BIT] && asleep
        |-> ##1 asleep ##[WAKE_LO:WAKE_HI] !asleep)
        else $error("register wake not within stabilisation window");
    sleep_cause_a: assert property ($rose(asleep) |-> ack && $past(we))
        else $error("sleep entered without a write");
    rdata_hold_a: assert property (!ack |-> $stable(rdata))
        else $error("link read data changed without ack");

    cover property (pwr_wr && wdata[slp_pkg::SLEEP_BIT]);
    cover property ($fell(asleep));
    cover property (ack && !we);
endmodule

// ==== sim/sleep_wakeup_control_tb_top.sv ====
/*
 Self-checking testbench: host and device ends joined by the link, APB stimulus,
 a register and sleep model in the bench, and the link checker beside the interface.
 Assumes a 200 MHz clock and a short wake-up count for simulation.
*/
`timescale 1ns/1ps
module sleep_wakeup_control_tb_top;
    localparam int WAKE = 16;
    logic sys_clk_in = 0;
    logic rst_n_in = 0;
    logic psel, penable, pwrite, pready, pslverr, irq, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic touch, key, key_valid, osc_run, mem_run, rom_run;
    logic [7:0] kcode, key_code;
    logic [52:0] core;
    wire [52:0] pins;
    logic [7:0] mreg [logic [7:0]];
    int n_errors = 0;
    int n_checks = 0;
    int nkeys = 0;
    int nk0;
    logic [7:0] amap [4] = '{slp_pkg::ADDR_POWER, slp_pkg::ADDR_TOUCH0, slp_pkg::ADDR_KEY1,
        slp_pkg::ADDR_KEY2};

    always #2.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (key_valid === 1'b1) nkeys <= nkeys + 1;

    slp_link_if link ();
    slp_host u_slp_host (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr), .irq_out(irq),
        .link(link.host));
    slp_device #(.WAKE_CYCLES(WAKE)) u_slp_device (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .link(link.dev), .touch_event_in(touch), .key_press_in(key),
        .key_code_in(kcode), .key_code_out(key_code), .key_valid_out(key_valid),
        .osc_run_out(osc_run), .mem_run_out(mem_run), .rom_run_out(rom_run),
        .core_wait_n_in(core[52]), .core_int_n_in(core[51]), .core_ram_cs_n_in(core[50]),
        .core_ram_wr_n_in(core[49]), .core_rom_cs_n_in(core[48]), .core_vsync_in(core[47]),
        .core_hsync_in(core[46]), .core_pclk_in(core[45]),
        .core_pixel_data_valid_in(core[44]), .core_ram_oe_n_in(core[43]),
        .core_gpio_in(core[42:37]), .core_video_mem_addr_in(core[36:18]),
        .core_pixel_data_in(core[17:2]), .core_pwm1_in(core[1]), .core_pwm2_in(core[0]),
        .wait_n_out(pins[52]), .int_n_out(pins[51]), .ram_cs_n_out(pins[50]),
        .ram_wr_n_out(pins[49]), .rom_cs_n_out(pins[48]), .vsync_out(pins[47]),
        .hsync_out(pins[46]), .pclk_out(pins[45]), .pixel_data_valid_out(pins[44]),
        .ram_oe_n_out(pins[43]), .gpio_out(pins[42:37]), .video_mem_addr_out(pins[36:18]),
        .pixel_data_out(pins[17:2]), .pwm1_out(pins[1]), .pwm2_out(pins[0]));
    slp_link_props #(.WAKE_CYCLES(WAKE)) u_slp_link_props (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .asleep(link.asleep));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tmo();
        n_errors++;
        $display("Error at %0t: wait ran out", $time);
        end_of_test();
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sleep forces fixed levels, but both PWM outputs keep following the core.
    task automatic chk_pins(input bit s);
        chk(pins, s ? {9'h1ff, 42'h0, core[1:0]} : core);
        chk({osc_run, mem_run, rom_run}, s ? 3'b000 : 3'b111);
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        r = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    // One device register access through the command register; a read is compared with the model, a write updates it.
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        apb(1'b1, slp_pkg::OFF_CMD, {1'b1, 14'h0, w, a, d});
        n = 0;
        do begin
            apb(1'b0, slp_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (r[slp_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 20);
        if (n >= 20) tmo();
        if (w && mreg.exists(a)) mreg[a] = d;
        if (!w) chk(r[15:8], mreg.exists(a) ? mreg[a] : 8'h00);
    endtask

    task automatic wait_awake();
        int n;
        n = 0;
        while (link.asleep !== 1'b0 && n < WAKE + 100) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= WAKE + 100) tmo();
        // The wake interrupt is registered one edge after asleep is seen low.
        @(posedge sys_clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        tmo();
    end

    initial begin
        {psel, penable, pwrite, touch, key} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        kcode = 8'h00;
        void'($urandom(32'ha1cf98b7));
        core = 53'({$urandom(), $urandom()});
        mreg[8'h01] = 8'h00;
        mreg[8'h70] = 8'h00;
        mreg[8'hc0] = 8'h00;
        mreg[8'hc1] = 8'h00;
        repeat (20) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        foreach (mreg[a]) dev(1'b0, a, 8'h00);
        dev(1'b0, 8'h55, 8'h00);
        apb(1'b0, slp_pkg::OFF_IRQ_MASK, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({se, r}, 33'h100000000);
        chk_pins(1'b0);
        for (int i = 0; i < 12; i++) begin
            logic [7:0] a;
            logic [7:0] d;
            a = i % 5 == 4 ? 8'h33 : amap[i % 4];
            d = 8'($urandom()) & (a == 8'h01 ? 8'hfd : 8'hff);
            dev(1'b1, a, d);
            dev(1'b0, a, 8'h00);
        end
        apb(1'b1, slp_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'b0, slp_pkg::OFF_IRQ_STATUS, 32'h0);
        dev(1'b0, 8'h01, 8'h00);
        chk(irq, 1'b1);
        apb(1'b0, slp_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(r[1:0], 2'b01);
        chk(irq, 1'b0);
        apb(1'b1, slp_pkg::OFF_IRQ_MASK, 32'h2);
        dev(1'b1, 8'hc1, 8'h00);
        dev(1'b1, 8'h70, 8'h80);
        dev(1'b1, 8'h01, 8'h02);
        chk(link.asleep, 1'b1);
        chk_pins(1'b1);
        kcode <= 8'($urandom());
        key <= 1'b1;
        touch <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        chk(link.asleep, 1'b1);
        key <= 1'b0;
        touch <= 1'b0;
        dev(1'b0, 8'h01, 8'h00);
        dev(1'b1, 8'h01, 8'h00);
        wait_awake();
        chk(irq, 1'b1);
        chk_pins(1'b0);
        apb(1'b0, slp_pkg::OFF_IRQ_STATUS, 32'h0);
        chk(r[1], 1'b1);
        dev(1'b1, 8'h70, 8'h88);
        dev(1'b1, 8'h01, 8'h02);
        touch <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        touch <= 1'b0;
        wait_awake();
        mreg[8'h01] = 8'h00;
        dev(1'b0, 8'h01, 8'h00);
        dev(1'b1, 8'h70, 8'h00);
        dev(1'b1, 8'hc0, 8'h80);
        dev(1'b1, 8'hc1, 8'h80);
        dev(1'b1, 8'h01, 8'h02);
        nk0 = nkeys;
        key <= 1'b1;
        wait_awake();
        repeat (5) @(posedge sys_clk_in);
        key <= 1'b0;
        mreg[8'h01] = 8'h00;
        dev(1'b0, 8'h01, 8'h00);
        chk(nkeys, nk0);
        key <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        key <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        chk(nkeys, nk0 + 1);
        chk(key_code, kcode);
        end_of_test();
    end
endmodule
